// File: apar_pkg.sv
// constants, field layouts and carrier types for the analog power and alarm registers
package apar_pkg;

   // serial frame: one command byte, then the register word msb first
   localparam int APAR_CMD_BITS = 8;
   localparam int APAR_CMD_READ_POS = 7;
   localparam logic [6:0] APAR_ADDR_CONV_A = 7'h01;
   localparam logic [6:0] APAR_ADDR_CONV_B = 7'h02;
   localparam logic [6:0] APAR_ADDR_REF = 7'h03;
   localparam logic [6:0] APAR_ADDR_ALARM = 7'h04;
   localparam logic [6:0] APAR_ADDR_CLKCTL = 7'h05;

   // word widths of each register
   localparam int APAR_CONV_BITS = 16;
   localparam int APAR_REF_BITS = 8;
   localparam int APAR_ALARM_BITS = 24;
   localparam int APAR_CLKCTL_BITS = 16;
   localparam int APAR_RD_BITS = 24;

   // field positions
   localparam int APAR_CODE_BITS = 10;
   localparam int APAR_EN_LSB = 13;
   localparam int APAR_SECOND_BITS = 20;
   localparam int APAR_ALARM_LSB = 4;
   localparam int APAR_UNLOCK_POS = 15;
   localparam int APAR_ALARM_EN_POS = 14;

   // values after reset
   localparam logic [2:0] APAR_EN_RESET = 3'h0;
   localparam logic [9:0] APAR_CODE_RESET = 10'h000;
   localparam logic [7:0] APAR_REF_RESET = 8'h00;
   localparam logic [19:0] APAR_ALARM_RESET = 20'h00000;

   // reference output in mV and detect threshold step in mV
   localparam logic [11:0] APAR_REF_MV_LOW = 12'h4E2;
   localparam logic [11:0] APAR_REF_MV_MID = 12'h800;
   localparam logic [11:0] APAR_REF_MV_HIGH = 12'h9C4;
   localparam logic [7:0] APAR_THR_STEP_MV = 8'h32;

   // frame length counter
   localparam logic [5:0] APAR_CNT_MAX = 6'h3F;

   typedef enum {APAR_TWO_CONV, APAR_ONE_CONV, APAR_NO_CONV} apar_variant_type;

   typedef struct packed {
      logic [1:0] level;
      logic bulk_off;
      logic bulk_on;
      logic detect_en;
      logic [2:0] thr_sel;
   } apar_ref_type;

   typedef struct packed {
      logic [2:0] power_en;
      logic [9:0] code_a;
      logic [9:0] code_b;
   } apar_conv_type;

endpackage

// File: apar_regs.sv
// serial register bank: converter control, reference/detect control and seconds alarm
// Functional notes
// - second converter code updates on the rising link edge of its last bit
// - converter codes are ten bits, right justified in a 16-bit word
// - top three enable bits are one shared copy seen through both words
// - two-converter variant: bit15 conv a, bit14 conv b, bit13 amp one; reset zero
// - no-converter variant: top bits enable amps; lower bits unused
// - reference select: 00 off, 01 1.25 V, 10 2.048 V, 11 2.5 V
// - reference byte: level, bulk off, bulk on, detect enable, threshold; resets zero
// - bulk off written one clears adc enable and all power enables
// - bulk on written one sets adc enable and all power enables
// - both bulk bits written one: bulk on wins
// - detect enable powers comparator; host keeps adc enable set to use it
// - threshold: top bit zero gives 0 mV, else 50 to 200 mV
// - alarm holds 20 seconds bits at 23..4, compared with low counter bits
// - alarm writes taken only while the write unlock bit is set
// - alarm shifts as three bytes msb first, committed on the last bit
// - chip select rising early discards the alarm write
// - enabled match sets flag and interrupt unless interrupt masked
// - match while asleep wakes the part
// - alarm is one shot: enable clears itself on trigger
// - mask does not suppress the user pin alarm output
// - first converter code updates on the rising link edge of its last bit
// - unlock zero blocks alarm and enable writes; unlock resets zero
`timescale 1ns/1ps
module apar_regs
   import apar_pkg::*;
#(
   parameter apar_variant_type VARIANT = APAR_TWO_CONV
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   input wire logic [19:0] rtc_second_count_in,
   input wire logic asleep_in,
   input wire logic alarm_irq_mask_in,
   input wire logic alarm_user_io_pins_route_in,
   input wire logic alarm_flag_clear_in,
   output apar_conv_type conv_out,
   output logic adc_power_enable_out,
   output logic [1:0] reference_level_select_out,
   output logic [11:0] ref_output_mv_out,
   output logic detect_comparator_enable_out,
   output logic [7:0] detect_threshold_mv_out,
   output logic alarm_enable_out,
   output logic alarm_flag_out,
   output logic irq_out,
   output logic wake_out,
   output logic user_io_pins_alarm_out
);

   // link side state
   logic [31:0] shift_reg;
   logic [31:0] shift_next;
   logic [5:0] cnt_reg;
   logic [7:0] cmd_reg;
   logic [23:0] rd_shift_reg;
   logic sdo_reg;
   logic sdo_oe_reg;
   apar_conv_type conv_reg;
   apar_ref_type ref_reg;
   logic adc_en_reg;
   logic [11:0] ref_mv_reg;
   logic [7:0] thr_mv_reg;
   logic [19:0] alarm_reg;
   logic unlock_reg;
   logic en_wr_val_reg;
   logic en_wr_tgl_reg;
   logic alm_tgl_reg;
   logic [1:0] en_rd_sync_reg;
   logic link_rst_reg;

   // system clock side state
   logic [2:0] en_tgl_sync_reg;
   logic [2:0] alm_tgl_sync_reg;
   logic [19:0] alarm_cmp_reg;
   logic alarm_en_reg;
   logic flag_reg;
   logic irq_reg;
   logic wake_reg;
   logic user_io_pins_reg;
   logic trigger;
   logic flag_next;

   // frame decode
   logic [5:0] frame_last;
   logic wr_go;
   logic wr_conv_a;
   logic wr_conv_b;
   logic wr_ref;
   logic wr_alarm;
   logic wr_ctl;
   apar_ref_type ref_in;

   // readback word for an address, left justified in 24 bits
   function automatic logic [23:0] read_word(input logic [6:0] addr);
      logic [15:0] conv_a_word;
      logic [15:0] conv_b_word;
      conv_a_word = '0;
      conv_b_word = '0;
      conv_a_word[15:APAR_EN_LSB] = conv_reg.power_en;
      conv_b_word[15:APAR_EN_LSB] = conv_reg.power_en;
      if (VARIANT != APAR_NO_CONV) begin
         conv_a_word[APAR_CODE_BITS-1:0] = conv_reg.code_a;
      end
      if (VARIANT == APAR_TWO_CONV) begin
         conv_b_word[APAR_CODE_BITS-1:0] = conv_reg.code_b;
      end
      unique case (addr)
         APAR_ADDR_CONV_A: read_word = {conv_a_word, 8'h00};
         APAR_ADDR_CONV_B: read_word = {conv_b_word, 8'h00};
         APAR_ADDR_REF: read_word = {ref_reg, 16'h0000};
         APAR_ADDR_ALARM: read_word = {alarm_reg, 4'h0};
         APAR_ADDR_CLKCTL: read_word = {unlock_reg, en_rd_sync_reg[1], 22'h000000};
         default: read_word = 24'h000000;
      endcase
   endfunction

   // command byte plus data word length, less one
   always_comb begin
      unique case (cmd_reg[6:0])
         APAR_ADDR_CONV_A: frame_last = 6'(APAR_CMD_BITS + APAR_CONV_BITS - 1);
         APAR_ADDR_CONV_B: frame_last = 6'(APAR_CMD_BITS + APAR_CONV_BITS - 1);
         APAR_ADDR_REF: frame_last = 6'(APAR_CMD_BITS + APAR_REF_BITS - 1);
         APAR_ADDR_ALARM: frame_last = 6'(APAR_CMD_BITS + APAR_ALARM_BITS - 1);
         APAR_ADDR_CLKCTL: frame_last = 6'(APAR_CMD_BITS + APAR_CLKCTL_BITS - 1);
         default: frame_last = APAR_CNT_MAX;
      endcase
   end

   // a write lands on the edge that shifts in its last bit
   assign shift_next = {shift_reg[30:0], sdi_in};
   assign wr_go = !cs_n_in && !cmd_reg[APAR_CMD_READ_POS] &&
                  (cnt_reg >= 6'(APAR_CMD_BITS)) && (cnt_reg == frame_last);
   assign wr_conv_a = wr_go && (cmd_reg[6:0] == APAR_ADDR_CONV_A);
   assign wr_conv_b = wr_go && (cmd_reg[6:0] == APAR_ADDR_CONV_B);
   assign wr_ref = wr_go && (cmd_reg[6:0] == APAR_ADDR_REF);
   assign wr_alarm = wr_go && (cmd_reg[6:0] == APAR_ADDR_ALARM);
   assign wr_ctl = wr_go && (cmd_reg[6:0] == APAR_ADDR_CLKCTL);
   assign ref_in = shift_next[7:0];

   // link side reset held from the system clock, since the link clock may stand still
   always_ff @(posedge clk_in) begin
      link_rst_reg <= rst_in;
   end

   // shifter and bit counter; chip select high drops any partial frame
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         shift_reg <= '0;
         cnt_reg <= '0;
         cmd_reg <= '0;
         rd_shift_reg <= '0;
      end else begin
         shift_reg <= shift_next;
         if (cnt_reg != APAR_CNT_MAX) begin
            cnt_reg <= cnt_reg + 6'h01;
         end
         if (cnt_reg == 6'(APAR_CMD_BITS - 1)) begin
            cmd_reg <= shift_next[7:0];
            rd_shift_reg <= read_word(shift_next[6:0]);
         end else begin
            rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
         end
      end
   end

   // read data changes on the falling edge for the host's rising-edge sample
   always_ff @(negedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         sdo_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
      end else begin
         sdo_reg <= rd_shift_reg[23];
         sdo_oe_reg <= cmd_reg[APAR_CMD_READ_POS] && (cnt_reg >= 6'(APAR_CMD_BITS));
      end
   end

   // converter control words and the shared enable bits
   always_ff @(posedge sclk_in or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         conv_reg.power_en <= APAR_EN_RESET;
         conv_reg.code_a <= APAR_CODE_RESET;
         conv_reg.code_b <= APAR_CODE_RESET;
         adc_en_reg <= 1'b0;
      end else if (wr_ref && ref_in.bulk_on) begin
         conv_reg.power_en <= 3'h7;
         adc_en_reg <= 1'b1;
      end else if (wr_ref && ref_in.bulk_off) begin
         conv_reg.power_en <= 3'h0;
         adc_en_reg <= 1'b0;
      end else if (wr_conv_a) begin
         conv_reg.power_en <= shift_next[15:APAR_EN_LSB];
         if (VARIANT != APAR_NO_CONV) begin
            conv_reg.code_a <= shift_next[APAR_CODE_BITS-1:0];
         end
      end else if (wr_conv_b) begin
         conv_reg.power_en <= shift_next[15:APAR_EN_LSB];
         if (VARIANT == APAR_TWO_CONV) begin
            conv_reg.code_b <= shift_next[APAR_CODE_BITS-1:0];
         end
      end
   end

   // reference and detect byte with its decoded levels
   always_ff @(posedge sclk_in or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         ref_reg <= APAR_REF_RESET;
         ref_mv_reg <= 12'h000;
         thr_mv_reg <= 8'h00;
      end else if (wr_ref) begin
         ref_reg <= ref_in;
         unique case (ref_in.level)
            2'b00: ref_mv_reg <= 12'h000;
            2'b01: ref_mv_reg <= APAR_REF_MV_LOW;
            2'b10: ref_mv_reg <= APAR_REF_MV_MID;
            2'b11: ref_mv_reg <= APAR_REF_MV_HIGH;
         endcase
         if (ref_in.thr_sel[2]) begin
            thr_mv_reg <= 8'(APAR_THR_STEP_MV * ({1'b0, ref_in.thr_sel[1:0]} + 3'h1));
         end else begin
            thr_mv_reg <= 8'h00;
         end
      end
   end

   // alarm value and unlock bit; a new value is handed over by toggle
   always_ff @(posedge sclk_in or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         alarm_reg <= APAR_ALARM_RESET;
         unlock_reg <= 1'b0;
         en_wr_val_reg <= 1'b0;
         en_wr_tgl_reg <= 1'b0;
         alm_tgl_reg <= 1'b0;
      end else begin
         if (wr_alarm && unlock_reg) begin
            alarm_reg <= shift_next[23:APAR_ALARM_LSB];
            alm_tgl_reg <= !alm_tgl_reg;
         end
         if (wr_ctl) begin
            unlock_reg <= shift_next[APAR_UNLOCK_POS];
            if (unlock_reg) begin
               en_wr_val_reg <= shift_next[APAR_ALARM_EN_POS];
               en_wr_tgl_reg <= !en_wr_tgl_reg;
            end
         end
      end
   end

   // alarm enable brought back for readback
   always_ff @(posedge sclk_in or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         en_rd_sync_reg <= 2'b00;
      end else begin
         en_rd_sync_reg <= {en_rd_sync_reg[0], alarm_en_reg};
      end
   end

   // toggles from the link side, synchronised then edge detected
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         en_tgl_sync_reg <= 3'h0;
         alm_tgl_sync_reg <= 3'h0;
      end else begin
         en_tgl_sync_reg <= {en_tgl_sync_reg[1:0], en_wr_tgl_reg};
         alm_tgl_sync_reg <= {alm_tgl_sync_reg[1:0], alm_tgl_reg};
      end
   end

   // compare copy; the link value is stable for many cycles after its toggle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         alarm_cmp_reg <= APAR_ALARM_RESET;
      end else if (alm_tgl_sync_reg[2] != alm_tgl_sync_reg[1]) begin
         alarm_cmp_reg <= alarm_reg;
      end
   end

   // match against the low counter bits
   assign trigger = alarm_en_reg && (rtc_second_count_in == alarm_cmp_reg);
   assign flag_next = trigger || (flag_reg && !alarm_flag_clear_in);

   // alarm enable: written by host, cleared by its own trigger
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         alarm_en_reg <= 1'b0;
      end else if (en_tgl_sync_reg[2] != en_tgl_sync_reg[1]) begin
         alarm_en_reg <= en_wr_val_reg;
      end else if (trigger) begin
         alarm_en_reg <= 1'b0;
      end
   end

   // flag, interrupt, wake and user pin outputs; set wins over clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flag_reg <= 1'b0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
         user_io_pins_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
         irq_reg <= flag_next && !alarm_irq_mask_in;
         wake_reg <= trigger && asleep_in;
         user_io_pins_reg <= flag_next && alarm_user_io_pins_route_in;
      end
   end

   assign sdo_out = sdo_reg;
   assign sdo_oe_out = sdo_oe_reg;
   assign conv_out = conv_reg;
   assign adc_power_enable_out = adc_en_reg;
   assign reference_level_select_out = ref_reg.level;
   assign ref_output_mv_out = ref_mv_reg;
   assign detect_comparator_enable_out = ref_reg.detect_en;
   assign detect_threshold_mv_out = thr_mv_reg;
   assign alarm_enable_out = alarm_en_reg;
   assign alarm_flag_out = flag_reg;
   assign irq_out = irq_reg;
   assign wake_out = wake_reg;
   assign user_io_pins_alarm_out = user_io_pins_reg;

   // checks on the system clock side
   AST_FLAG_ON_MATCH: assert property (@(posedge clk_in) disable iff (rst_in)
      alarm_en_reg && (rtc_second_count_in == alarm_cmp_reg) |=> alarm_flag_out)
      else $error("alarm match did not set the flag");
   AST_ONE_SHOT: assert property (@(posedge clk_in) disable iff (rst_in)
      trigger && (en_tgl_sync_reg[2] == en_tgl_sync_reg[1]) |=> !alarm_enable_out)
      else $error("alarm enable not cleared after trigger");
   AST_IRQ_UNMASKED: assert property (@(posedge clk_in) disable iff (rst_in)
      trigger && !alarm_irq_mask_in |=> irq_out && alarm_flag_out)
      else $error("unmasked alarm did not raise interrupt");
   AST_IRQ_MASKED: assert property (@(posedge clk_in) disable iff (rst_in)
      alarm_irq_mask_in |=> !irq_out)
      else $error("masked alarm raised interrupt");
   AST_USER_IO_PINS_IGNORES_MASK: assert property (@(posedge clk_in) disable iff (rst_in)
      trigger && alarm_user_io_pins_route_in && alarm_irq_mask_in |=> user_io_pins_alarm_out)
      else $error("user pin alarm suppressed by mask");
   AST_WAKE: assert property (@(posedge clk_in) disable iff (rst_in)
      trigger && asleep_in |=> wake_out ##1 (!wake_out || $past(trigger)))
      else $error("asleep match did not wake once");

   // checks on the link side
   AST_BULK_ON: assert property (@(posedge sclk_in) disable iff (link_rst_reg)
      wr_ref && ref_in.bulk_on |=> (conv_out.power_en == 3'h7) && adc_power_enable_out)
      else $error("bulk on did not set all enables");
   AST_BULK_OFF: assert property (@(posedge sclk_in) disable iff (link_rst_reg)
      wr_ref && ref_in.bulk_off && !ref_in.bulk_on |=>
      (conv_out.power_en == 3'h0) && !adc_power_enable_out)
      else $error("bulk off did not clear all enables");
   AST_ALARM_LOCKED: assert property (@(posedge sclk_in) disable iff (link_rst_reg)
      !unlock_reg |=> $stable(alarm_reg))
      else $error("alarm value changed while locked");
   AST_CODE_B_UPDATE: assert property (@(posedge sclk_in) disable iff (link_rst_reg)
      wr_conv_b && (VARIANT == APAR_TWO_CONV) |=>
      conv_out.code_b == $past(shift_next[9:0]))
      else $error("second converter code not updated on last bit");
   AST_SHARED_ENABLES: assert property (@(posedge sclk_in) disable iff (link_rst_reg)
      wr_conv_b && !wr_ref |=> conv_out.power_en == $past(shift_next[15:13]))
      else $error("enable bits written through second word not shared");

endmodule

// File: apar_host.sv
// serial port master model for the register bank's four-wire link
`timescale 1ns/1ps
module apar_host (
   output logic sclk_out,
   output logic cs_n_out,
   output logic sdi_out,
   input wire logic sdo_in,
   input wire logic sdo_oe_in
);
   // link parked: clock still low, chip select high
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   // one frame: command byte, then w data bits msb first, cut after nbits
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] data, input int w,
                       input int nbits, output logic [23:0] rd);
      logic [31:0] sh;
      begin
         sh = {cmd, data << (24 - w)};
         rd = 24'h000000;
         #7;
         cs_n_out <= 1'b0;
         for (int i = 0; i < nbits; i++) begin
            sdi_out <= sh[31 - i];
            #16;
            sclk_out <= 1'b1;
            // undriven data line reads as unknown so it never matches
            if (i >= 8) begin
               rd = {rd[22:0], sdo_oe_in ? sdo_in : 1'bx};
            end
            #16;
            sclk_out <= 1'b0;
         end
         #16;
         cs_n_out <= 1'b1;
         sdi_out <= ~sdi_out; // released line holds no stale level
      end
   endtask
endmodule

// File: tb_analog_power_alarm_regs.sv
// self-checking bench for the analog power and alarm register bank
`timescale 1ns/1ps
module tb_analog_power_alarm_regs
   import apar_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic sclk, cs_n, sdi, sdo, sdo_oe;
   logic [19:0] rtc_cnt = 20'h00005;
   logic asleep = 1'b0;
   logic irq_mask = 1'b0;
   logic route = 1'b0;
   logic flag_clr = 1'b0;
   apar_conv_type conv;
   logic adc_en, det_en, al_en, al_flag, irq, wake, user_io_pins;
   logic [1:0] ref_sel;
   logic [11:0] ref_mv;
   logic [7:0] thr_mv;
   logic [23:0] rd;
   logic [11:0] mv [4] = '{12'h000, APAR_REF_MV_LOW, APAR_REF_MV_MID, APAR_REF_MV_HIGH};
   // detect thresholds 50, 100, 150, 200 mV
   logic [7:0] thr [4] = '{8'h32, 8'h64, 8'h96, 8'hC8};
   int num_errors = 0;
   int n_tests = 0;

   // system clock, 40 ns period
   always #20 clk_in = ~clk_in;

   apar_host apar_host_i (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
      .sdo_in(sdo), .sdo_oe_in(sdo_oe));

   apar_regs apar_regs_i (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .rtc_second_count_in(rtc_cnt),
      .asleep_in(asleep), .alarm_irq_mask_in(irq_mask), .alarm_user_io_pins_route_in(route),
      .alarm_flag_clear_in(flag_clr), .conv_out(conv), .adc_power_enable_out(adc_en),
      .reference_level_select_out(ref_sel), .ref_output_mv_out(ref_mv),
      .detect_comparator_enable_out(det_en), .detect_threshold_mv_out(thr_mv),
      .alarm_enable_out(al_en), .alarm_flag_out(al_flag), .irq_out(irq),
      .wake_out(wake), .user_io_pins_alarm_out(user_io_pins));

   // verdict and end of run
   task automatic summarize();
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // value comparison
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // let n edges pass, then settle
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic wr(input logic [6:0] a, input logic [23:0] d, input int w);
      logic [23:0] junk;
      apar_host_i.xfer({1'b0, a}, d, w, 8 + w, junk);
      tick(4);
   endtask

   task automatic rdreg(input logic [6:0] a, input int w);
      apar_host_i.xfer({1'b1, a}, 24'h000000, w, 8 + w, rd);
      tick(2);
   endtask

   // bounded wait on alarm flag (which=1) or alarm enable (which=0)
   task automatic wait_for(input int which, input logic v);
      int k;
      k = 0;
      while (((which != 0) ? al_flag : al_en) !== v && k < 20) begin
         tick(1);
         k++;
      end
      if (((which != 0) ? al_flag : al_en) !== v) begin
         num_errors++;
         $display("unexpected at %0t: wait ran out", $time);
         summarize();
      end
   endtask

   task automatic t_reset();
      chk({1'b0, conv}, 24'h000000, "conv reset");
      chk({14'h0000, sdo_oe, wake, adc_en, det_en, ref_sel, al_en, al_flag, irq, user_io_pins},
          24'h000000, "outputs reset");
      chk({4'h0, ref_mv, thr_mv}, 24'h000000, "levels reset");
      rdreg(APAR_ADDR_REF, 8);
      chk(rd, 24'h000000, "ref reset");
   endtask

   task automatic t_conv();
      wr(APAR_ADDR_CONV_A, 24'h008123, 16);
      chk({1'b0, conv}, {1'b0, 3'h4, 10'h123, 10'h000}, "conv a");
      wr(APAR_ADDR_CONV_B, 24'h006FFF, 16);
      chk({1'b0, conv}, {1'b0, 3'h3, 10'h123, 10'h3FF}, "conv b");
      rdreg(APAR_ADDR_CONV_A, 16);
      chk(rd, 24'h006123, "conv a read");
      rdreg(APAR_ADDR_CONV_B, 16);
      chk(rd, 24'h0063FF, "conv b read");
      // frame cut one bit short must leave everything alone
      apar_host_i.xfer({1'b0, APAR_ADDR_CONV_B}, 24'h00FFFF, 16, 23, rd);
      tick(4);
      chk({1'b0, conv}, {1'b0, 3'h3, 10'h123, 10'h3FF}, "conv b cut");
      rdreg(7'h7F, 16);
      chk(rd, 24'h000000, "unmapped read");
   endtask

   task automatic t_ref();
      logic [7:0] b;
      for (int i = 0; i < 8; i++) begin
         b = {i[1:0], 2'h0, i[0], i[2:0]};
         wr(APAR_ADDR_REF, {16'h0000, b}, 8);
         chk({10'h000, ref_sel, ref_mv}, {10'h000, i[1:0], mv[i[1:0]]}, "ref mv");
         chk({16'h0000, thr_mv}, {16'h0000, i[2] ? thr[i[1:0]] : 8'h00},
             "threshold");
         chk({23'h000000, det_en}, {23'h000000, i[0]}, "detect en");
         rdreg(APAR_ADDR_REF, 8);
         chk(rd, {16'h0000, b}, "ref read");
         chk({adc_en, conv}, {1'b1, 3'h7, 10'h123, 10'h3FF}, "bulk idle");
      end
   endtask

   task automatic t_bulk();
      wr(APAR_ADDR_REF, 24'h000010, 8);
      chk({20'h00000, adc_en, conv.power_en}, 24'h00000F, "bulk on");
      wr(APAR_ADDR_REF, 24'h000020, 8);
      chk({20'h00000, adc_en, conv.power_en}, 24'h000000, "bulk off");
      wr(APAR_ADDR_REF, 24'h000030, 8);
      chk({20'h00000, adc_en, conv.power_en}, 24'h00000F, "bulk both");
      chk({14'h0000, conv.code_a}, 24'h000123, "codes kept");
   endtask

   // bring the counter onto the alarm value and judge the outcome
   task automatic fire(input logic [3:0] exp);
      @(posedge clk_in) rtc_cnt <= 20'h01234;
      wait_for(1, 1'b1);
      chk({20'h00000, al_flag, irq, user_io_pins, wake}, {20'h00000, exp}, "trigger");
      chk({23'h000000, al_en}, 24'h000000, "one shot");
      tick(1);
      chk({23'h000000, wake}, 24'h000000, "wake pulse");
   endtask

   task automatic t_alarm();
      wr(APAR_ADDR_CLKCTL, 24'h004000, 16);
      tick(6);
      chk({23'h000000, al_en}, 24'h000000, "locked enable");
      wr(APAR_ADDR_ALARM, 24'h01234F, 24);
      rdreg(APAR_ADDR_ALARM, 24);
      chk(rd, 24'h000000, "locked alarm");
      wr(APAR_ADDR_CLKCTL, 24'h008000, 16);
      wr(APAR_ADDR_ALARM, 24'h01234F, 24);
      rdreg(APAR_ADDR_ALARM, 24);
      chk(rd, 24'h012340, "alarm read");
      apar_host_i.xfer({1'b0, APAR_ADDR_ALARM}, 24'hABCDE0, 24, 31, rd);
      tick(4);
      rdreg(APAR_ADDR_ALARM, 24);
      chk(rd, 24'h012340, "alarm cut");
      @(posedge clk_in) begin
         asleep <= 1'b1;
         irq_mask <= 1'b1;
         route <= 1'b1;
      end
      wr(APAR_ADDR_CLKCTL, 24'h00C000, 16);
      wait_for(0, 1'b1);
      rdreg(APAR_ADDR_CLKCTL, 16);
      chk(rd, 24'h00C000, "ctl read");
      fire(4'hB);
      rdreg(APAR_ADDR_CLKCTL, 16);
      chk(rd, 24'h008000, "ctl after shot");
      // match still present, flag cleared: a one-shot alarm stays quiet
      @(posedge clk_in) flag_clr <= 1'b1;
      @(posedge clk_in) flag_clr <= 1'b0;
      tick(4);
      chk({21'h000000, al_flag, irq, user_io_pins}, 24'h000000, "no repeat");
      @(posedge clk_in) begin
         rtc_cnt <= 20'h00005;
         asleep <= 1'b0;
         irq_mask <= 1'b0;
         route <= 1'b0;
      end
      wr(APAR_ADDR_CLKCTL, 24'h00C000, 16);
      wait_for(0, 1'b1);
      fire(4'hC);
   endtask

   // main sequence
   initial begin
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      tick(4);
      t_reset();
      t_conv();
      t_bulk();
      t_ref();
      t_alarm();
      summarize();
   end
endmodule
